// ---- debug_link_pkg.sv ----
package debug_link_pkg;
  // ==========================================================
  // widths
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned CHECK_BYTES = 4;
  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] CMD_BITS = 4'h2;
  localparam logic [CNT_W-1:0] DATA_BITS = 4'h8;

  // ==========================================================
  // selector codes
  localparam logic [7:0] SEL_DEVICE_IDENT = 8'h00;
  localparam logic [7:0] SEL_REVISION_IDENT = 8'h01;
  localparam logic [7:0] SEL_CORE_HALT_CONTROL = 8'h02;
  localparam logic [7:0] SEL_PROG_MEM_CONTROL = 8'hDF;
  localparam logic [7:0] SEL_PROG_MEM_DATA = 8'hBF;
  localparam logic [7:0] SEL_PROG_MEM_STATUS = 8'hB7;
  localparam logic [7:0] SEL_PROG_MEM_ADDR_HIGH = 8'hAF;
  localparam logic [7:0] SEL_PROG_MEM_ADDR_LOW = 8'hAE;
  localparam logic [7:0] SEL_CHECK_WORD_BYTE0 = 8'hA9;
  localparam logic [7:0] SEL_CHECK_WORD_BYTE1 = 8'hAA;
  localparam logic [7:0] SEL_CHECK_WORD_BYTE2 = 8'hAB;
  localparam logic [7:0] SEL_CHECK_WORD_BYTE3 = 8'hAC;

  // ==========================================================
  // reset values and field positions
  localparam logic [7:0] SELECT_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
  localparam int unsigned BUSY_BIT = 0;
  localparam int unsigned REFUSED_BIT = 1;
  localparam int unsigned HALT_BIT = 0;
  localparam int unsigned PROG_EN_BIT = 0;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 16'h0001;

  // ==========================================================
  // link commands, first two bits after the start bit
  typedef enum logic [1:0] {
    CMD_DATA_READ = 2'b00,
    CMD_DATA_WRITE = 2'b01,
    CMD_SELECT_READ = 2'b10,
    CMD_SELECT_WRITE = 2'b11
  } link_cmd_t;

  typedef enum logic [1:0] {
    L_IDLE = 2'b00,
    L_CMD = 2'b01,
    L_WDATA = 2'b10,
    L_RDATA = 2'b11
  } link_state_t;
endpackage : debug_link_pkg

// ---- debug_link_register_select.sv ----
// Notes on behaviour
// - two pins only; clock is input
// - select register picks data command target
// - 0x00 reaches read-only device ident
// - 0x01 reaches read-only revision ident
// - 0x02 reaches core halt control
// - 0xDF reaches memory programming control
// - 0xBF reaches memory data byte
// - 0xB7 reaches memory status
// - 0xAF/0xAE reach address high/low bytes
// - 0xA9..0xAC reach check word bytes 0..3
// - select read returns busy flag only, not selector
// - busy high during memory access; tool waits
// - halt control stops core for memory work
// - programming control enables writes, resets zero
module debug_link_register_select
  import debug_link_pkg::*;
#(
  parameter logic [7:0] DEVICE_IDENT_VALUE = 8'h5A, // arbitrary value
  parameter logic [7:0] REVISION_IDENT_VALUE = 8'h01 // arbitrary value
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic debug_clock_pin_i,
  input wire logic debug_data_pin_i,
  output logic debug_data_pin_o,
  output logic debug_data_pin_oe_o,
  output logic core_halt_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic [BYTE_W-1:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [BYTE_W-1:0] mem_rdata_i
);

  // ==========================================================
  // state of the link domain
  typedef struct packed {
    link_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [1:0] cmd;
    logic [BYTE_W-1:0] shreg;
    logic [BYTE_W-1:0] select;
    logic [BYTE_W-1:0] halt_ctl;
    logic [BYTE_W-1:0] prog_ctl;
    logic [BYTE_W-1:0] prog_dat;
    logic [ADDR_W-1:0] addr;
    logic [CHECK_BYTES*BYTE_W-1:0] check;
    logic [ADDR_W-1:0] op_addr;
    logic [BYTE_W-1:0] op_wdata;
    logic refused;
    logic req_tgl;
    logic op_we;
    logic done_s1;
    logic done_s2;
    logic done_seen;
    logic dout;
    logic doe;
  } link_t;

  // ==========================================================
  // state of the system-clock domain
  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic active;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] wdata;
    logic [BYTE_W-1:0] rdata;
    logic done_tgl;
    logic halt_s1;
    logic halt_s2;
  } core_t;

  // ==========================================================
  // reset images of both domains
  localparam link_t LINK_RESET = '{
    state: L_IDLE,
    cnt: '0,
    cmd: '0,
    shreg: REG_RESET,
    select: SELECT_RESET,
    halt_ctl: REG_RESET,
    prog_ctl: REG_RESET,
    prog_dat: REG_RESET,
    addr: ADDR_RESET,
    check: '0,
    op_addr: ADDR_RESET,
    op_wdata: REG_RESET,
    refused: 1'b0,
    req_tgl: 1'b0,
    op_we: 1'b0,
    done_s1: 1'b0,
    done_s2: 1'b0,
    done_seen: 1'b0,
    dout: 1'b0,
    doe: 1'b0
  };
  localparam core_t CORE_RESET = '{
    req_s1: 1'b0,
    req_s2: 1'b0,
    req_seen: 1'b0,
    active: 1'b0,
    we: 1'b0,
    addr: ADDR_RESET,
    wdata: REG_RESET,
    rdata: REG_RESET,
    done_tgl: 1'b0,
    halt_s1: 1'b0,
    halt_s2: 1'b0
  };

  // ==========================================================
  // frame bit counter, stepped in the command and data phases of a frame
  function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] c);
    return c + 4'h1;
  endfunction : cnt_step

  function automatic logic cnt_last(input logic [CNT_W-1:0] c,
                                    input logic [CNT_W-1:0] n);
    return cnt_step(c) == n;
  endfunction : cnt_last

  link_t lq;
  link_t ld;
  core_t cq;
  core_t cd;
  logic lrst_s1_q;
  logic lrst_s2_q;
  logic crst_s1_q;
  logic crst_s2_q;
  logic busy;

  // ==========================================================
  // read multiplexer shared by the data read path
  function automatic logic [BYTE_W-1:0] sel_read(input link_t s,
                                                 input logic bsy);
    logic [BYTE_W-1:0] v;
    v = REG_RESET;
    unique case (s.select)
      SEL_DEVICE_IDENT: v = DEVICE_IDENT_VALUE;
      SEL_REVISION_IDENT: v = REVISION_IDENT_VALUE;
      SEL_CORE_HALT_CONTROL: v = s.halt_ctl;
      SEL_PROG_MEM_CONTROL: v = s.prog_ctl;
      SEL_PROG_MEM_DATA: v = s.prog_dat;
      SEL_PROG_MEM_STATUS: begin
        v[BUSY_BIT] = bsy;
        v[REFUSED_BIT] = s.refused;
      end
      SEL_PROG_MEM_ADDR_HIGH: v = s.addr[ADDR_W-1:BYTE_W];
      SEL_PROG_MEM_ADDR_LOW: v = s.addr[BYTE_W-1:0];
      SEL_CHECK_WORD_BYTE0: v = s.check[0*BYTE_W +: BYTE_W];
      SEL_CHECK_WORD_BYTE1: v = s.check[1*BYTE_W +: BYTE_W];
      SEL_CHECK_WORD_BYTE2: v = s.check[2*BYTE_W +: BYTE_W];
      SEL_CHECK_WORD_BYTE3: v = s.check[3*BYTE_W +: BYTE_W];
      default: v = REG_RESET;
    endcase
    return v;
  endfunction : sel_read

  // ==========================================================
  // reset release, one synchroniser per domain
  always_ff @(posedge debug_clock_pin_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lrst_s1_q <= 1'b0;
      lrst_s2_q <= 1'b0;
    end else begin
      lrst_s1_q <= 1'b1;
      lrst_s2_q <= lrst_s1_q;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      crst_s1_q <= 1'b0;
      crst_s2_q <= 1'b0;
    end else begin
      crst_s1_q <= 1'b1;
      crst_s2_q <= crst_s1_q;
    end
  end

  // ==========================================================
  // link domain: bit engine and target registers
  // busy spans launch to the return of the done toggle
  assign busy = lq.req_tgl != lq.done_seen;

  always_comb begin
    ld = lq;
    ld.done_s1 = cq.done_tgl;
    ld.done_s2 = lq.done_s1;
    // done toggle came back; core data is stable until the next launch
    if (lq.done_s2 != lq.done_seen) begin
      ld.done_seen = lq.done_s2;
      if (!lq.op_we) begin
        ld.prog_dat = cq.rdata;
      end
      ld.addr = lq.addr + ADDR_STEP;
    end
    unique case (lq.state)
      L_IDLE: begin
        ld.doe = 1'b0;
        ld.dout = 1'b0;
        // low level on the data pin is the start bit
        if (!debug_data_pin_i) begin
          ld.state = L_CMD;
          ld.cnt = '0;
        end
      end
      L_CMD: begin
        ld.cmd = {lq.cmd[0], debug_data_pin_i};
        ld.cnt = cnt_step(lq.cnt);
        if (cnt_last(lq.cnt, CMD_BITS)) begin
          ld.cnt = '0;
          if (ld.cmd == CMD_DATA_WRITE || ld.cmd == CMD_SELECT_WRITE) begin
            ld.state = L_WDATA;
          end else begin
            ld.state = L_RDATA;
            if (ld.cmd == CMD_SELECT_READ) begin
              ld.shreg = REG_RESET;
              ld.shreg[BUSY_BIT] = busy;
            end else begin
              ld.shreg = sel_read(lq, busy);
              // a read of the data byte fetches the next one behind it
              if (lq.select == SEL_PROG_MEM_DATA && !busy) begin
                ld.req_tgl = ~lq.req_tgl;
                ld.op_we = 1'b0;
                ld.op_addr = lq.addr;
              end
            end
            ld.dout = ld.shreg[BYTE_W-1];
            ld.doe = 1'b1;
          end
        end
      end
      L_WDATA: begin
        ld.shreg = {lq.shreg[BYTE_W-2:0], debug_data_pin_i};
        ld.cnt = cnt_step(lq.cnt);
        if (cnt_last(lq.cnt, DATA_BITS)) begin
          ld.state = L_IDLE;
          if (lq.cmd == CMD_SELECT_WRITE) begin
            ld.select = ld.shreg;
          end else begin
            unique case (lq.select)
              SEL_CORE_HALT_CONTROL: ld.halt_ctl = ld.shreg;
              SEL_PROG_MEM_CONTROL: begin
                ld.prog_ctl = ld.shreg;
                ld.refused = 1'b0;
              end
              SEL_PROG_MEM_DATA: begin
                ld.prog_dat = ld.shreg;
                // writes need the enable and an idle engine
                if (lq.prog_ctl[PROG_EN_BIT] && !busy) begin
                  ld.req_tgl = ~lq.req_tgl;
                  ld.op_we = 1'b1;
                  ld.op_addr = lq.addr;
                  ld.op_wdata = ld.shreg;
                end else begin
                  ld.refused = 1'b1;
                end
              end
              SEL_PROG_MEM_ADDR_HIGH:
                ld.addr[ADDR_W-1:BYTE_W] = ld.shreg;
              SEL_PROG_MEM_ADDR_LOW:
                ld.addr[BYTE_W-1:0] = ld.shreg;
              SEL_CHECK_WORD_BYTE0:
                ld.check[0*BYTE_W +: BYTE_W] = ld.shreg;
              SEL_CHECK_WORD_BYTE1:
                ld.check[1*BYTE_W +: BYTE_W] = ld.shreg;
              SEL_CHECK_WORD_BYTE2:
                ld.check[2*BYTE_W +: BYTE_W] = ld.shreg;
              SEL_CHECK_WORD_BYTE3:
                ld.check[3*BYTE_W +: BYTE_W] = ld.shreg;
              // identity bytes, the status byte and unknown codes drop the write
              default: ld.select = lq.select;
            endcase
          end
        end
      end
      L_RDATA: begin
        ld.cnt = cnt_step(lq.cnt);
        ld.shreg = {lq.shreg[BYTE_W-2:0], 1'b0};
        ld.dout = ld.shreg[BYTE_W-1];
        if (cnt_last(lq.cnt, DATA_BITS)) begin
          ld.state = L_IDLE;
          ld.doe = 1'b0;
          ld.dout = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge debug_clock_pin_i or negedge lrst_s2_q) begin
    if (!lrst_s2_q) begin
      lq <= LINK_RESET;
    end else begin
      lq <= ld;
    end
  end

  // ==========================================================
  // system-clock domain: memory port and halt request
  always_comb begin
    cd = cq;
    cd.req_s1 = lq.req_tgl;
    cd.req_s2 = cq.req_s1;
    cd.halt_s1 = lq.halt_ctl[HALT_BIT];
    cd.halt_s2 = cq.halt_s1;
    // launch copies stand still until done returns, so one sample is safe
    if (!cq.active && cq.req_s2 != cq.req_seen) begin
      cd.req_seen = cq.req_s2;
      cd.active = 1'b1;
      cd.we = lq.op_we;
      cd.addr = lq.op_addr;
      cd.wdata = lq.op_wdata;
    end
    if (cq.active && mem_ack_i) begin
      cd.active = 1'b0;
      if (!cq.we) begin
        cd.rdata = mem_rdata_i;
      end
      cd.done_tgl = ~cq.done_tgl;
    end
  end

  always_ff @(posedge mclk_i or negedge crst_s2_q) begin
    if (!crst_s2_q) begin
      cq <= CORE_RESET;
    end else if (clk_en_i) begin
      cq <= cd;
    end
  end

  // ==========================================================
  // outputs
  assign debug_data_pin_o = lq.dout;
  assign debug_data_pin_oe_o = lq.doe;
  assign core_halt_o = cq.halt_s2;
  assign mem_req_o = cq.active;
  assign mem_we_o = cq.we;
  assign mem_addr_o = cq.addr;
  assign mem_wdata_o = cq.wdata;

endmodule : debug_link_register_select

// ---- debug_link_register_select_checker.sv ----
module debug_link_register_select_checker
  import debug_link_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic debug_clock_pin_i,
  input wire logic debug_data_pin_i,
  input wire logic debug_data_pin_o,
  input wire logic debug_data_pin_oe_o,
  input wire logic core_halt_o,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [ADDR_W-1:0] mem_addr_o,
  input wire logic [BYTE_W-1:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [BYTE_W-1:0] mem_rdata_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // memory port: request stands whole until answered
  chk_req_hold:
    assert property (@(posedge mclk_i) disable iff (!resetn_i)
      mem_req_o && !mem_ack_i |=> mem_req_o) else $error("req dropped");
  chk_req_drop:
    assert property (@(posedge mclk_i) disable iff (!resetn_i)
      mem_req_o && mem_ack_i && clk_en_i |=> !mem_req_o)
      else $error("req stuck");
  chk_addr_hold:
    assert property (@(posedge mclk_i) disable iff (!resetn_i)
      mem_req_o && !mem_ack_i |=> $stable(mem_addr_o))
      else $error("addr moved");
  chk_kind_hold:
    assert property (@(posedge mclk_i) disable iff (!resetn_i)
      mem_req_o && !mem_ack_i |=> $stable(mem_we_o)) else $error("we moved");
  chk_data_hold:
    assert property (@(posedge mclk_i) disable iff (!resetn_i)
      mem_req_o && mem_we_o && !mem_ack_i |=> $stable(mem_wdata_o))
      else $error("wdata moved");
  // a new op needs a whole link frame, so a gap is certain
  chk_one_op:
    assert property (@(posedge mclk_i) disable iff (!resetn_i)
      $fell(mem_req_o) |=> !mem_req_o [*8]) else $error("ops overlap");
  // ==========================================================
  // link side
  chk_read_len:
    assert property (@(posedge debug_clock_pin_i) disable iff (!resetn_i)
      $rose(debug_data_pin_oe_o) |-> debug_data_pin_oe_o [*8] ##1
      !debug_data_pin_oe_o) else $error("read drive length");
  chk_read_cmd:
    assert property (@(posedge debug_clock_pin_i) disable iff (!resetn_i)
      $rose(debug_data_pin_oe_o) |-> !$past(debug_data_pin_i) &&
      !$past(debug_data_pin_i, 3)) else $error("drive without read");
  cov_mem_wr: cover property (@(posedge mclk_i) mem_req_o && mem_we_o
    && mem_ack_i);
  cov_mem_rd: cover property (@(posedge mclk_i) mem_req_o && !mem_we_o
    && mem_ack_i);
  cov_link_rd: cover property (@(posedge debug_clock_pin_i)
    $rose(debug_data_pin_oe_o));
endmodule : debug_link_register_select_checker

bind debug_link_register_select debug_link_register_select_checker u_chk (.*);

// ---- debug_link_tool.sv ----
module debug_link_tool (
  output logic clk_o,
  output logic drv_o,
  output logic en_o,
  input wire logic line_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // tool owns the link clock; it stands low between frames
  logic [7:0] rd_q = 8'h00;
  bit done_q;
  initial begin
    clk_o = 1'b0;
    drv_o = 1'b1;
    en_o = 1'b1;
  end
  task automatic tick(input logic b);
    drv_o = b;
    #16 clk_o = 1'b1;
    #16 clk_o = 1'b0;
  endtask : tick
  // read bits are taken on falling edges, mid-bit
  task automatic xfer(input logic [1:0] c, input logic [7:0] w,
                      input bit note, output logic [7:0] r);
    r = 8'h00;
    tick(1'b0);
    tick(c[1]);
    tick(c[0]);
    if (!c[0]) begin
      en_o = 1'b0;
      for (int i = 0; i < 8; i++) begin
        r = {r[6:0], line_i};
        tick(1'b1);
      end
      en_o = 1'b1;
    end else begin
      for (int i = 7; i >= 0; i--) tick(w[i]);
    end
    // two idle edges settle the device before the next start bit
    repeat (2) tick(1'b1);
    if (note) begin
      rd_q = r;
      done_q = ~done_q;
    end
  endtask : xfer
endmodule : debug_link_tool

// ---- debug_link_register_select_tb.sv ----
module debug_link_register_select_tb import debug_link_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] ID = 8'h3C; // arbitrary value
  localparam logic [7:0] REV = 8'h07; // arbitrary value
  logic mclk_i, resetn_i = 0, clk_en_i = 1, mem_ack_i = 0;
  logic [7:0] mem_rdata_i = 8'h00, wdata, v, d, n_wr = 8'h00;
  logic [15:0] addr;
  logic pin_o, oe, halt, req, we, tck, tdrv, ten;
  logic [7:0] mem [256];
  logic [7:0] rw [8] = '{8'h02, 8'hDF, 8'hAF, 8'hAE, 8'hA9, 8'hAA,
    8'hAB, 8'hAC};
  logic [7:0] exp_q [$];
  int n_errors = 0, tests_run = 0, dly = 0, mst = 0;
  // released line floats to the pull-up level
  wire logic line_w = oe ? pin_o : (ten ? tdrv : 1'b1);
  debug_link_register_select #(.DEVICE_IDENT_VALUE(ID),
    .REVISION_IDENT_VALUE(REV)) u_dut (.mclk_i(mclk_i),
    .resetn_i(resetn_i), .clk_en_i(clk_en_i), .debug_clock_pin_i(tck),
    .debug_data_pin_i(line_w), .debug_data_pin_o(pin_o),
    .debug_data_pin_oe_o(oe), .core_halt_o(halt), .mem_req_o(req),
    .mem_we_o(we), .mem_addr_o(addr), .mem_wdata_o(wdata),
    .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i));
  debug_link_tool u_tool (.clk_o(tck), .drv_o(tdrv), .en_o(ten),
    .line_i(line_w));
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  // ==========================================================
  // memory responder; clock enable only drops while no op pends
  initial forever begin
    @(posedge mclk_i);
    #1;
    mem_ack_i = 1'b0;
    clk_en_i = req | ($urandom % 4 != 0);
    if (mst == 0 && req) begin
      mst = 1;
      dly = 100 + $urandom % 100;
    end else if (mst == 1) begin
      dly = dly - 1;
      if (dly == 0) begin
        mem_ack_i = 1'b1;
        mem_rdata_i = mem[addr[7:0]];
        if (we) begin
          mem[addr[7:0]] = wdata;
          n_wr++;
        end
        mst = 2;
      end
    end else if (mst == 2 && !req) mst = 0;
  end
  task automatic chk(input string what, input logic [7:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  always @(u_tool.done_q)
    chk("read", u_tool.rd_q, exp_q.pop_front());
  task automatic go(input logic [1:0] c, input logic [7:0] w, input bit n);
    logic [7:0] r;
    u_tool.xfer(c, w, n, r);
  endtask : go
  task automatic sel(input logic [7:0] s);
    go(CMD_SELECT_WRITE, s, 1'b0);
  endtask : sel
  task automatic rdx(input logic [7:0] e);
    exp_q.push_back(e);
    go(CMD_DATA_READ, 8'h00, 1'b1);
  endtask : rdx
  task automatic st(input logic [7:0] e);
    exp_q.push_back(e);
    go(CMD_SELECT_READ, 8'h00, 1'b1);
  endtask : st
  task automatic poll;
    logic [7:0] r;
    r = 8'h01;
    for (int i = 0; i < 60; i++) begin
      if (r[BUSY_BIT] !== 1'b0)
        u_tool.xfer(CMD_SELECT_READ, 8'h00, 1'b0, r);
    end
    chk("busy", r, 8'h00);
  endtask : poll
  task automatic test_done;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  initial begin
    #200000;
    n_errors++;
    $display("watchdog expired");
    test_done;
  end
  // ==========================================================
  // scenarios
  initial begin
    void'($urandom(11872));
    repeat (4) @(posedge mclk_i);
    #1 resetn_i = 1'b1;
    repeat (2) u_tool.tick(1'b1);
    st(8'h00);
    sel(SEL_DEVICE_IDENT);
    go(CMD_DATA_WRITE, ~ID, 1'b0);
    rdx(ID);
    sel(SEL_REVISION_IDENT);
    go(CMD_DATA_WRITE, ~REV, 1'b0);
    rdx(REV);
    foreach (rw[i]) begin
      v = 8'($urandom);
      sel(rw[i]);
      rdx(REG_RESET);
      go(CMD_DATA_WRITE, v, 1'b0);
      rdx(v);
      if (rw[i] == SEL_CORE_HALT_CONTROL)
        chk("halt", {7'h00, halt}, {7'h00, v[0]});
    end
    st(8'h00);
    rdx(v);
    sel(8'h55);
    go(CMD_DATA_WRITE, 8'hA5, 1'b0);
    rdx(8'h00);
    st(8'h00);
    d = 8'($urandom);
    sel(SEL_PROG_MEM_CONTROL);
    go(CMD_DATA_WRITE, 8'h01, 1'b0);
    sel(SEL_PROG_MEM_ADDR_HIGH);
    go(CMD_DATA_WRITE, 8'h00, 1'b0);
    sel(SEL_PROG_MEM_ADDR_LOW);
    go(CMD_DATA_WRITE, 8'h10, 1'b0);
    sel(SEL_PROG_MEM_DATA);
    go(CMD_DATA_WRITE, d, 1'b0);
    st(8'h01);
    poll;
    chk("writes", n_wr, 8'h01);
    sel(SEL_PROG_MEM_ADDR_LOW);
    rdx(8'h11);
    go(CMD_DATA_WRITE, 8'h10, 1'b0);
    sel(SEL_PROG_MEM_DATA);
    go(CMD_DATA_READ, 8'h00, 1'b0);
    poll;
    rdx(d);
    poll;
    sel(SEL_PROG_MEM_CONTROL);
    go(CMD_DATA_WRITE, 8'h00, 1'b0);
    sel(SEL_PROG_MEM_DATA);
    go(CMD_DATA_WRITE, ~d, 1'b0);
    sel(SEL_PROG_MEM_STATUS);
    rdx(8'h02);
    sel(SEL_PROG_MEM_CONTROL);
    go(CMD_DATA_WRITE, 8'h01, 1'b0);
    sel(SEL_PROG_MEM_STATUS);
    rdx(8'h00);
    chk("writes", n_wr, 8'h01);
    test_done;
  end
endmodule : debug_link_register_select_tb
